// ===== hdl/acf_dev_end.sv
// Purpose: device end: parses host frames, builds device frames
// Assumes: link bytes are already deserialised, same clock
// Notes:   two-entry buffer toward the user absorbs stalls
`timescale 1ns/1ps
`include "acf_params.svh"
module acf_dev_end (
  input  wire logic        clk_i,       // device clock
  input  wire logic        rst_i,       // async reset, high
  input  wire logic [1:0]  mode_i,      // api_mode_select
  input  wire logic        fmt_i,       // api_output_format
  acf_link_if.dev          lnk,         // byte link
  output logic      [7:0]  rx_data_o,   // frame data byte
  output logic             rx_last_o,   // last byte of frame
  output logic             rx_good_o,   // checksum good, with last
  output logic             rx_valid_o,  // rx byte valid
  input  wire logic        rx_ready_i,  // user takes rx byte
  input  wire logic [7:0]  tx_data_i,   // outgoing frame data byte
  input  wire logic [15:0] tx_len_i,    // frame data length, with first byte
  input  wire logic        tx_valid_i,  // tx byte valid
  output logic             tx_ready_o   // tx byte taken
);
  // ****************************************
  // receive decode
  // ****************************************
  acf_pkg::acf_pst_t p_st;
  logic        esc_mode;
  logic        esc_q;
  logic [7:0]  in_b;
  logic        take;
  logic        is_escb;
  logic        is_delim;
  logic        dbyte;
  logic [7:0]  sum_nx;
  logic        sum_ok;
  logic        id_ok;
  logic [15:0] p_len;
  logic [7:0]  p_sum;
  logic        p_first;
  logic        p_drop;
  logic        pend_v;
  logic [7:0]  pend_b;
  logic        buf_room;
  logic        push_v;
  logic        push_last;
  logic        push_good;
  logic        err_set;
  logic [7:0]  err_code;
  logic        err_pend;
  logic        err_clr;
  logic [7:0]  err_code_q;

  assign esc_mode = (mode_i == `ACF_MODE_ESC);
  assign take     = lnk.h2d_valid & lnk.h2d_ready;
  assign is_escb  = esc_mode & ~esc_q & (lnk.h2d_data == `ACF_ESC);
  // in plain mode 7E is data once a frame is open
  assign is_delim = (lnk.h2d_data == `ACF_DELIM) & (esc_mode | (p_st == acf_pkg::P_HUNT));
  assign in_b     = esc_q ? (lnk.h2d_data ^ `ACF_XOR) : lnk.h2d_data;
  assign dbyte    = take & ~is_delim & ~is_escb;
  assign sum_nx   = p_sum + in_b;
  assign sum_ok   = (sum_nx == `ACF_SUM_GOOD);
  assign id_ok    = (in_b == `ACF_ID_CMD_NOW) | (in_b == `ACF_ID_CMD_Q) |
                    (in_b == `ACF_ID_TX_REQ) | (in_b == `ACF_ID_TX_EXPL) |
                    (in_b == `ACF_ID_REMOTE);
  assign lnk.h2d_ready = buf_room;

  // one byte held back so the last one can carry the verdict
  assign push_v = (take & is_delim & (p_st != acf_pkg::P_HUNT) & pend_v) |
                  (dbyte & (p_st == acf_pkg::P_DATA) & pend_v) |
                  (dbyte & (p_st == acf_pkg::P_CSUM) & pend_v);
  assign push_last = (p_st != acf_pkg::P_DATA) | is_delim;
  assign push_good = (p_st == acf_pkg::P_CSUM) & ~is_delim & sum_ok;

  assign err_set  = (take & is_delim & (p_st != acf_pkg::P_HUNT)) |
                    (dbyte & (p_st == acf_pkg::P_LENL) & (p_len[15:8] == 8'h00) &
                     (in_b == 8'h00)) |
                    (dbyte & (p_st == acf_pkg::P_CSUM) & ~sum_ok);
  assign err_code = ((p_st == acf_pkg::P_CSUM) & ~is_delim) ? `ACF_ST_BADSUM : `ACF_ST_BADFRM;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      p_st    <= acf_pkg::P_HUNT;
      esc_q   <= 1'b0;
      p_len   <= 16'h0000;
      p_sum   <= 8'h00;
      p_first <= 1'b0;
      p_drop  <= 1'b0;
      pend_v  <= 1'b0;
      pend_b  <= 8'h00;
    end else if (take) begin
      esc_q <= is_escb & (p_st != acf_pkg::P_HUNT);
      if (is_delim) begin
        p_st   <= acf_pkg::P_LENH;
        pend_v <= 1'b0;
      end else if (!is_escb) begin
        case (p_st)
          acf_pkg::P_HUNT: p_st <= acf_pkg::P_HUNT;
          acf_pkg::P_LENH: begin
            p_len[15:8] <= in_b;
            p_st        <= acf_pkg::P_LENL;
          end
          acf_pkg::P_LENL: begin
            p_len[7:0] <= in_b;
            p_sum      <= 8'h00;
            p_first    <= 1'b1;
            p_st       <= ({p_len[15:8], in_b} == 16'h0000) ? acf_pkg::P_HUNT
                                                            : acf_pkg::P_DATA;
          end
          acf_pkg::P_DATA: begin
            p_sum   <= sum_nx;
            pend_b  <= in_b;
            p_first <= 1'b0;
            if (p_first) begin
              p_drop <= ~id_ok;
              pend_v <= id_ok;
            end else begin
              pend_v <= ~p_drop;
            end
            p_len <= p_len - 16'h0001;
            if (p_len == 16'h0001) begin
              p_st <= acf_pkg::P_CSUM;
            end
          end
          acf_pkg::P_CSUM: begin
            p_st   <= acf_pkg::P_HUNT;
            pend_v <= 1'b0;
          end
          default: p_st <= acf_pkg::P_HUNT;
        endcase
      end
    end
  end

  // set wins over the clear by the builder
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      err_pend   <= 1'b0;
      err_code_q <= 8'h00;
    end else if (err_set) begin
      err_pend   <= 1'b1;
      err_code_q <= err_code;
    end else if (err_clr) begin
      err_pend <= 1'b0;
    end
  end

  // ****************************************
  // two-entry receive buffer
  // ****************************************
  logic [9:0] buf_mem [0:1];
  logic       buf_wp;
  logic       buf_rp;
  logic [1:0] buf_cnt;
  logic       pop;

  assign buf_room   = (buf_cnt != 2'h2);
  assign pop        = rx_valid_o & rx_ready_i;
  assign rx_valid_o = (buf_cnt != 2'h0);
  assign rx_data_o  = buf_mem[buf_rp][7:0];
  assign rx_last_o  = buf_mem[buf_rp][8];
  assign rx_good_o  = buf_mem[buf_rp][9];

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      buf_mem[0] <= 10'h000;
      buf_mem[1] <= 10'h000;
      buf_wp     <= 1'b0;
      buf_rp     <= 1'b0;
      buf_cnt    <= 2'h0;
    end else begin
      if (push_v) begin
        buf_mem[buf_wp] <= {push_good, push_last, pend_b};
        buf_wp          <= ~buf_wp;
      end
      if (pop) begin
        buf_rp <= ~buf_rp;
      end
      buf_cnt <= buf_cnt + {1'b0, push_v} - {1'b0, pop};
    end
  end

  // ****************************************
  // transmit builder
  // ****************************************
  acf_pkg::acf_bst_t b_st;
  logic [15:0] b_len;
  logic [15:0] b_cnt;
  logic [7:0]  b_sum;
  logic [7:0]  h0;
  logic [7:0]  h1;
  logic [7:0]  id_map;
  logic        out_v;
  logic [7:0]  out_b;
  logic        sec_v;
  logic [7:0]  sec_b;
  logic        out_free;
  logic        src_v;
  logic [7:0]  src_b;
  logic        src_e;
  logic        src_take;
  logic        need_esc;

  assign id_map = (fmt_i & (tx_data_i == `ACF_ID_RX_PKT)) ? `ACF_ID_RX_EXPL : tx_data_i;
  assign out_free = ~sec_v & (~out_v | lnk.d2h_ready);
  assign src_take = src_v & out_free;
  assign need_esc = esc_mode & src_e &
                    ((src_b == `ACF_DELIM) | (src_b == `ACF_ESC) |
                     (src_b == `ACF_XON) | (src_b == `ACF_XOFF));
  assign err_clr  = (b_st == acf_pkg::B_IDLE) & err_pend;
  assign tx_ready_o = ((b_st == acf_pkg::B_IDLE) & ~err_pend) |
                      (b_st == acf_pkg::B_GET1) | (b_st == acf_pkg::B_SKIP) |
                      ((b_st == acf_pkg::B_BODY) & out_free);
  assign lnk.d2h_valid = out_v;
  assign lnk.d2h_data  = out_b;

  always_comb begin
    src_v = 1'b1;
    src_e = 1'b1;
    src_b = 8'h00;
    case (b_st)
      acf_pkg::B_DELIM: begin
        src_b = `ACF_DELIM;
        src_e = 1'b0;
      end
      acf_pkg::B_LENH: src_b = b_len[15:8];
      acf_pkg::B_LENL: src_b = b_len[7:0];
      acf_pkg::B_B0:   src_b = h0;
      acf_pkg::B_B1:   src_b = h1;
      acf_pkg::B_BODY: begin
        src_v = tx_valid_i;
        src_b = tx_data_i;
      end
      acf_pkg::B_CSUM: src_b = `ACF_SUM_GOOD - b_sum;
      default:         src_v = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_v <= 1'b0;
      out_b <= 8'h00;
      sec_v <= 1'b0;
      sec_b <= 8'h00;
    end else if (src_take) begin
      out_v <= 1'b1;
      out_b <= need_esc ? `ACF_ESC : src_b;
      sec_v <= need_esc;
      sec_b <= src_b ^ `ACF_XOR;
    end else if (out_v && lnk.d2h_ready) begin
      out_v <= sec_v;
      out_b <= sec_b;
      sec_v <= 1'b0;
    end
  end

  // first two bytes held so a silenced response never starts
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      b_st  <= acf_pkg::B_IDLE;
      b_len <= 16'h0000;
      b_cnt <= 16'h0000;
      b_sum <= 8'h00;
      h0    <= 8'h00;
      h1    <= 8'h00;
    end else begin
      case (b_st)
        acf_pkg::B_IDLE: begin
          if (err_pend) begin
            h0    <= `ACF_ID_MSTAT;
            h1    <= err_code_q;
            b_len <= `ACF_MSTAT_LEN;
            b_st  <= acf_pkg::B_DELIM;
          end else if (tx_valid_i) begin
            h0    <= id_map;
            b_len <= tx_len_i;
            b_st  <= (tx_len_i > 16'h0001) ? acf_pkg::B_GET1 : acf_pkg::B_DELIM;
          end
        end
        acf_pkg::B_GET1: begin
          if (tx_valid_i) begin
            h1    <= tx_data_i;
            b_cnt <= b_len - 16'h0002;
            if ((h0 == `ACF_ID_CMD_RSP) && (tx_data_i == 8'h00)) begin
              b_st <= (b_len == 16'h0002) ? acf_pkg::B_IDLE : acf_pkg::B_SKIP;
            end else begin
              b_st <= acf_pkg::B_DELIM;
            end
          end
        end
        acf_pkg::B_SKIP: begin
          if (tx_valid_i) begin
            b_cnt <= b_cnt - 16'h0001;
            if (b_cnt == 16'h0001) begin
              b_st <= acf_pkg::B_IDLE;
            end
          end
        end
        acf_pkg::B_DELIM: if (src_take) b_st <= acf_pkg::B_LENH;
        acf_pkg::B_LENH:  if (src_take) b_st <= acf_pkg::B_LENL;
        acf_pkg::B_LENL:  if (src_take) b_st <= acf_pkg::B_B0;
        acf_pkg::B_B0: begin
          if (src_take) begin
            b_sum <= h0;
            b_st  <= (b_len > 16'h0001) ? acf_pkg::B_B1 : acf_pkg::B_CSUM;
          end
        end
        acf_pkg::B_B1: begin
          if (src_take) begin
            b_sum <= b_sum + h1;
            b_st  <= (b_len > 16'h0002) ? acf_pkg::B_BODY : acf_pkg::B_CSUM;
          end
        end
        acf_pkg::B_BODY: begin
          if (src_take) begin
            b_sum <= b_sum + tx_data_i;
            b_cnt <= b_cnt - 16'h0001;
            if (b_cnt == 16'h0001) begin
              b_st <= acf_pkg::B_CSUM;
            end
          end
        end
        acf_pkg::B_CSUM: if (src_take) b_st <= acf_pkg::B_IDLE;
        default:          b_st <= acf_pkg::B_IDLE;
      endcase
    end
  end
endmodule

// ===== hdl/acf_params.svh
// Purpose: constants of the framed serial codec
// Assumes: byte-wide link, one clock
// Notes:   status codes are local choices
`ifndef ACF_PARAMS_SVH
`define ACF_PARAMS_SVH
// ****************************************
// framing bytes
// ****************************************
`define ACF_DELIM      8'h7E
`define ACF_ESC        8'h7D
`define ACF_XOR        8'h20
`define ACF_XON        8'h11
`define ACF_XOFF       8'h13
`define ACF_SUM_GOOD   8'hFF
`define ACF_MODE_PLAIN 2'h1
`define ACF_MODE_ESC   2'h2
// ****************************************
// api identifiers
// ****************************************
`define ACF_ID_CMD_NOW 8'h08
`define ACF_ID_CMD_Q   8'h09
`define ACF_ID_TX_REQ  8'h10
`define ACF_ID_TX_EXPL 8'h11
`define ACF_ID_REMOTE  8'h17
`define ACF_ID_CMD_RSP 8'h88
`define ACF_ID_MSTAT   8'h8A
`define ACF_ID_TX_STAT 8'h8B
`define ACF_ID_RX_PKT  8'h90
`define ACF_ID_RX_EXPL 8'h91
`define ACF_ID_NODE    8'h95
`define ACF_ID_REM_RSP 8'h97
// ****************************************
// modem status codes and lengths
// ****************************************
`define ACF_ST_BADSUM  8'h01
`define ACF_ST_BADFRM  8'h02
`define ACF_MSTAT_LEN  16'h0002
`endif

// ===== hdl/acf_pkg.sv
// Purpose: state types of the framed serial codec
// Assumes: nothing
// Notes:   shared by both ends
package acf_pkg;
  typedef enum logic [2:0] {P_HUNT, P_LENH, P_LENL, P_DATA, P_CSUM} acf_pst_t;
  typedef enum logic [3:0] {
    B_IDLE, B_GET1, B_SKIP, B_DELIM, B_LENH, B_LENL, B_B0, B_B1, B_BODY, B_CSUM
  } acf_bst_t;
endpackage

// ===== hdl/acf_link_if.sv
// Purpose: byte link between host end and device end
// Assumes: both ends on one clock
// Notes:   valid/ready per direction
`timescale 1ns/1ps
interface acf_link_if;
  logic [7:0] h2d_data;
  logic       h2d_valid;
  logic       h2d_ready;
  logic [7:0] d2h_data;
  logic       d2h_valid;
  logic       d2h_ready;
  modport dev (input h2d_data, h2d_valid, d2h_ready, output h2d_ready, d2h_data, d2h_valid);
  modport hst (output h2d_data, h2d_valid, d2h_ready, input h2d_ready, d2h_data, d2h_valid);
endinterface

// ===== hdl/acf_host_end.sv
// Purpose: host end: builds command frames, parses device frames
// Assumes: same clock as the device end
// Notes:   unknown frames never reach the user; corrupt ones reach it with rx_good_o low
`timescale 1ns/1ps
`include "acf_params.svh"
module acf_host_end (
  input  wire logic        clk_i,       // host clock
  input  wire logic        rst_i,       // async reset, high
  input  wire logic [1:0]  mode_i,      // api_mode_select
  acf_link_if.hst          lnk,         // byte link
  output logic      [7:0]  rx_data_o,   // frame data byte
  output logic             rx_last_o,   // last byte of frame
  output logic             rx_good_o,   // checksum good, with last
  output logic             rx_valid_o,  // rx byte valid
  input  wire logic        rx_ready_i,  // user takes rx byte
  input  wire logic [7:0]  tx_data_i,   // outgoing frame data byte
  input  wire logic [15:0] tx_len_i,    // frame data length, with first byte
  input  wire logic        tx_valid_i,  // tx byte valid
  output logic             tx_ready_o   // tx byte taken
);
  // ****************************************
  // receive decode
  // ****************************************
  acf_pkg::acf_pst_t p_st;
  logic        esc_mode;
  logic        esc_q;
  logic [7:0]  in_b;
  logic        take;
  logic        is_escb;
  logic        is_delim;
  logic        dbyte;
  logic [7:0]  sum_nx;
  logic        id_ok;
  logic [15:0] p_len;
  logic [7:0]  p_sum;
  logic        p_first;
  logic        p_drop;
  logic        pend_v;
  logic [7:0]  pend_b;
  logic        push_v;

  assign esc_mode = (mode_i == `ACF_MODE_ESC);
  assign take     = lnk.d2h_valid & lnk.d2h_ready;
  assign is_escb  = esc_mode & ~esc_q & (lnk.d2h_data == `ACF_ESC);
  assign is_delim = (lnk.d2h_data == `ACF_DELIM) & (esc_mode | (p_st == acf_pkg::P_HUNT));
  assign in_b     = esc_q ? (lnk.d2h_data ^ `ACF_XOR) : lnk.d2h_data;
  assign dbyte    = take & ~is_delim & ~is_escb;
  assign sum_nx   = p_sum + in_b;
  assign id_ok    = (in_b == `ACF_ID_CMD_RSP) | (in_b == `ACF_ID_MSTAT) |
                    (in_b == `ACF_ID_TX_STAT) | (in_b == `ACF_ID_RX_PKT) |
                    (in_b == `ACF_ID_RX_EXPL) | (in_b == `ACF_ID_NODE) |
                    (in_b == `ACF_ID_REM_RSP);
  assign lnk.d2h_ready = ~rx_valid_o | rx_ready_i;
  assign push_v = pend_v & ((take & is_delim & (p_st != acf_pkg::P_HUNT)) |
                            (dbyte & ((p_st == acf_pkg::P_DATA) | (p_st == acf_pkg::P_CSUM))));

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_valid_o <= 1'b0;
      rx_data_o  <= 8'h00;
      rx_last_o  <= 1'b0;
      rx_good_o  <= 1'b0;
    end else if (push_v) begin
      rx_valid_o <= 1'b1;
      rx_data_o  <= pend_b;
      rx_last_o  <= (p_st != acf_pkg::P_DATA) | is_delim;
      rx_good_o  <= (p_st == acf_pkg::P_CSUM) & ~is_delim & (sum_nx == `ACF_SUM_GOOD);
    end else if (rx_ready_i) begin
      rx_valid_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      p_st    <= acf_pkg::P_HUNT;
      esc_q   <= 1'b0;
      p_len   <= 16'h0000;
      p_sum   <= 8'h00;
      p_first <= 1'b0;
      p_drop  <= 1'b0;
      pend_v  <= 1'b0;
      pend_b  <= 8'h00;
    end else if (take) begin
      esc_q <= is_escb & (p_st != acf_pkg::P_HUNT);
      if (is_delim) begin
        p_st   <= acf_pkg::P_LENH;
        pend_v <= 1'b0;
      end else if (!is_escb) begin
        case (p_st)
          acf_pkg::P_HUNT: p_st <= acf_pkg::P_HUNT;
          acf_pkg::P_LENH: begin
            p_len[15:8] <= in_b;
            p_st        <= acf_pkg::P_LENL;
          end
          acf_pkg::P_LENL: begin
            p_len[7:0] <= in_b;
            p_sum      <= 8'h00;
            p_first    <= 1'b1;
            p_st       <= ({p_len[15:8], in_b} == 16'h0000) ? acf_pkg::P_HUNT
                                                            : acf_pkg::P_DATA;
          end
          acf_pkg::P_DATA: begin
            p_sum   <= sum_nx;
            pend_b  <= in_b;
            p_first <= 1'b0;
            if (p_first) begin
              p_drop <= ~id_ok;
              pend_v <= id_ok;
            end else begin
              pend_v <= ~p_drop;
            end
            p_len <= p_len - 16'h0001;
            if (p_len == 16'h0001) begin
              p_st <= acf_pkg::P_CSUM;
            end
          end
          acf_pkg::P_CSUM: begin
            p_st   <= acf_pkg::P_HUNT;
            pend_v <= 1'b0;
          end
          default: p_st <= acf_pkg::P_HUNT;
        endcase
      end
    end
  end

  // ****************************************
  // transmit builder
  // ****************************************
  acf_pkg::acf_bst_t b_st;
  logic [15:0] b_len;
  logic [15:0] b_cnt;
  logic [7:0]  b_sum;
  logic        out_v;
  logic [7:0]  out_b;
  logic        sec_v;
  logic [7:0]  sec_b;
  logic        out_free;
  logic        src_v;
  logic [7:0]  src_b;
  logic        src_take;
  logic        need_esc;

  assign out_free   = ~sec_v & (~out_v | lnk.h2d_ready);
  assign src_v      = (b_st == acf_pkg::B_BODY) ? tx_valid_i : (b_st != acf_pkg::B_IDLE);
  assign src_b      = (b_st == acf_pkg::B_DELIM) ? `ACF_DELIM :
                      (b_st == acf_pkg::B_LENH)  ? b_len[15:8] :
                      (b_st == acf_pkg::B_LENL)  ? b_len[7:0] :
                      (b_st == acf_pkg::B_BODY)  ? tx_data_i : (`ACF_SUM_GOOD - b_sum);
  assign src_take   = src_v & out_free;
  assign need_esc   = esc_mode & (b_st != acf_pkg::B_DELIM) &
                      ((src_b == `ACF_DELIM) | (src_b == `ACF_ESC) |
                       (src_b == `ACF_XON) | (src_b == `ACF_XOFF));
  assign tx_ready_o = (b_st == acf_pkg::B_BODY) & out_free;
  assign lnk.h2d_valid = out_v;
  assign lnk.h2d_data  = out_b;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_v <= 1'b0;
      out_b <= 8'h00;
      sec_v <= 1'b0;
      sec_b <= 8'h00;
    end else if (src_take) begin
      out_v <= 1'b1;
      out_b <= need_esc ? `ACF_ESC : src_b;
      sec_v <= need_esc;
      sec_b <= src_b ^ `ACF_XOR;
    end else if (out_v && lnk.h2d_ready) begin
      out_v <= sec_v;
      out_b <= sec_b;
      sec_v <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      b_st  <= acf_pkg::B_IDLE;
      b_len <= 16'h0000;
      b_cnt <= 16'h0000;
      b_sum <= 8'h00;
    end else begin
      case (b_st)
        acf_pkg::B_IDLE: begin
          if (tx_valid_i) begin
            b_len <= tx_len_i;
            b_cnt <= tx_len_i;
            b_sum <= 8'h00;
            b_st  <= acf_pkg::B_DELIM;
          end
        end
        acf_pkg::B_DELIM: if (src_take) b_st <= acf_pkg::B_LENH;
        acf_pkg::B_LENH:  if (src_take) b_st <= acf_pkg::B_LENL;
        acf_pkg::B_LENL:  if (src_take) b_st <= acf_pkg::B_BODY;
        acf_pkg::B_BODY: begin
          if (src_take) begin
            b_sum <= b_sum + tx_data_i;
            b_cnt <= b_cnt - 16'h0001;
            if (b_cnt <= 16'h0001) begin
              b_st <= acf_pkg::B_CSUM;
            end
          end
        end
        acf_pkg::B_CSUM: if (src_take) b_st <= acf_pkg::B_IDLE;
        default:          b_st <= acf_pkg::B_IDLE;
      endcase
    end
  end
endmodule

// ===== tb/acf_link_sva.sv
// Purpose: link checks for the codec pair
// Assumes: one clock, reset high
// Notes:   escape checks only in mode 2
`timescale 1ns/1ps
module acf_link_sva (
  input wire logic       clk_i,     // clock
  input wire logic       rst_i,     // reset
  input wire logic [1:0] mode_i,    // api_mode_select
  input wire logic [7:0] h2d_data,  // host byte
  input wire logic       h2d_valid, // host offers
  input wire logic       h2d_ready, // device takes
  input wire logic [7:0] d2h_data,  // device byte
  input wire logic       d2h_valid, // device offers
  input wire logic       d2h_ready  // host takes
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire  ht  = h2d_valid && h2d_ready;
  wire  dt  = d2h_valid && d2h_ready;
  wire  hs  = h2d_valid && !h2d_ready;
  wire  ds  = d2h_valid && !d2h_ready;
  wire  esc = mode_i == 2'h2;
  logic eh;
  logic ed;
  // ****************
  // checks
  // ****************
  // remembers a taken escape so the byte after it is judged apart
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      eh <= 1'b0;
      ed <= 1'b0;
    end else begin
      eh <= ht ? h2d_data == 8'h7D : eh;
      ed <= dt ? d2h_data == 8'h7D : ed;
    end
  end
  AST_H2D_HOLD: assert property (hs |=> h2d_valid && $stable(h2d_data))
    else $error("h2d byte moved");
  AST_D2H_HOLD: assert property (ds |=> d2h_valid && $stable(d2h_data))
    else $error("d2h byte moved");
  AST_H2D_START: assert property ($rose(h2d_valid) |-> h2d_data == 8'h7E)
    else $error("h2d frame start");
  AST_D2H_START: assert property ($rose(d2h_valid) |-> d2h_data == 8'h7E)
    else $error("d2h frame start");
  AST_H2D_ESC: assert property (esc && ht && eh |-> h2d_data inside {8'h5E, 8'h5D, 8'h31, 8'h33})
    else $error("h2d escape");
  AST_D2H_ESC: assert property (esc && dt && ed |-> d2h_data inside {8'h5E, 8'h5D, 8'h31, 8'h33})
    else $error("d2h escape");
  AST_H2D_RAW: assert property (esc && ht && !eh |-> !(h2d_data inside {8'h11, 8'h13}))
    else $error("h2d raw flow byte");
  AST_D2H_RAW: assert property (esc && dt && !ed |-> !(d2h_data inside {8'h11, 8'h13}))
    else $error("d2h raw flow byte");
  AST_RST_QUIET: assert property ($fell(rst_i) |-> !h2d_valid && !d2h_valid)
    else $error("link busy after reset");
  cover property (esc && ht && eh);
  cover property (dt && d2h_data == 8'h91);
  cover property (hs);
endmodule

// ===== tb/test_api_uart_frame_codec.sv
// Purpose: end-to-end bench for the codec pair
// Assumes: both ends on clk_i, reset high
// Notes:   a third end takes raw link bytes to force faults
`timescale 1ns/1ps
module test_api_uart_frame_codec;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [1:0]  mode  = 2'h1;
  logic        fmt   = 1'b0;
  logic [7:0]  txd[3] = '{default: 8'h00};
  logic [15:0] txl[3] = '{default: 16'h0000};
  logic        txv[3] = '{default: 1'b0};
  logic        rxr[3] = '{default: 1'b1};
  logic        txr[3];
  logic [7:0]  rxd[3];
  logic        rxl[3];
  logic        rxg[3];
  logic        rxv[3];
  logic [9:0]  rq[4][$];
  logic [7:0]  hid[6] = '{8'h08, 8'h09, 8'h10, 8'h11, 8'h20, 8'h17};
  logic [7:0]  did[7] = '{8'h88, 8'h8A, 8'h8B, 8'h97, 8'h95, 8'h42, 8'h90};
  int          num_errors = 0;
  int          n_tests = 0;
  int          cyc = 0;
  acf_link_if lnk ();
  acf_link_if lnk2 ();
  assign lnk2.h2d_data  = txd[2];
  assign lnk2.h2d_valid = txv[2];
  assign lnk2.d2h_ready = 1'b1;
  assign txr[2]         = lnk2.h2d_ready;
  acf_host_end acf_host_end_inst (.clk_i(clk_i), .rst_i(rst_i), .mode_i(mode), .lnk(lnk),
    .rx_data_o(rxd[0]), .rx_last_o(rxl[0]), .rx_good_o(rxg[0]), .rx_valid_o(rxv[0]),
    .rx_ready_i(rxr[0]), .tx_data_i(txd[0]), .tx_len_i(txl[0]), .tx_valid_i(txv[0]),
    .tx_ready_o(txr[0]));
  acf_dev_end acf_dev_end_inst (.clk_i(clk_i), .rst_i(rst_i), .mode_i(mode), .fmt_i(fmt),
    .lnk(lnk), .rx_data_o(rxd[1]), .rx_last_o(rxl[1]), .rx_good_o(rxg[1]),
    .rx_valid_o(rxv[1]), .rx_ready_i(rxr[1]), .tx_data_i(txd[1]), .tx_len_i(txl[1]),
    .tx_valid_i(txv[1]), .tx_ready_o(txr[1]));
  // fault end: its own user tx stays idle so only status frames leave it
  acf_dev_end acf_dev_end_inst_f (.clk_i(clk_i), .rst_i(rst_i), .mode_i(mode), .fmt_i(fmt),
    .lnk(lnk2), .rx_data_o(rxd[2]), .rx_last_o(rxl[2]), .rx_good_o(rxg[2]),
    .rx_valid_o(rxv[2]), .rx_ready_i(rxr[2]), .tx_data_i(txd[2]), .tx_len_i(txl[2]),
    .tx_valid_i(1'b0), .tx_ready_o());
  acf_link_sva acf_link_sva_inst (.clk_i(clk_i), .rst_i(rst_i), .mode_i(mode),
    .h2d_data(lnk.h2d_data), .h2d_valid(lnk.h2d_valid), .h2d_ready(lnk.h2d_ready),
    .d2h_data(lnk.d2h_data), .d2h_valid(lnk.d2h_valid), .d2h_ready(lnk.d2h_ready));
  // ****************
  // drivers and checks
  // ****************
  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    for (int i = 0; i < 3; i++) begin
      if (rxv[i] === 1'b1 && rxr[i])
        rq[i].push_back({rxl[i], rxg[i], rxd[i]});
    end
    if (lnk2.d2h_valid === 1'b1)
      rq[3].push_back({2'b00, lnk2.d2h_data});
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      conclude();
    end
  end
  task automatic conclude();
    if (num_errors == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // ready is looked at mid-cycle so the edge's own updates have landed
  task automatic send(input int p, input logic [7:0] b[$]);
    foreach (b[i]) begin
      txd[p] <= b[i];
      txl[p] <= 16'(b.size());
      txv[p] <= 1'b1;
      do @(negedge clk_i); while (txr[p] !== 1'b1);
      @(posedge clk_i);
    end
    txv[p] <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic want(input int p, input logic [7:0] e[$], input logic g, input bit mk = 1);
    logic [9:0] x;
    for (int k = 0; k < 400 && rq[p].size() < e.size(); k++) @(posedge clk_i);
    foreach (e[i]) begin
      x = (rq[p].size() > 0) ? rq[p].pop_front() : 10'h3FF;
      chk(x, {mk && i == e.size() - 1, mk && g && i == e.size() - 1, e[i]});
    end
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i  <= 1'b0;
    rxr[1] <= 1'b0;
    fork
      send(0, '{8'h10, 8'h52, 8'h7E, 8'h11, 8'h00});
      begin
        repeat (60) @(posedge clk_i);
        rxr[1] <= 1'b1;
      end
    join
    want(1, '{8'h10, 8'h52, 8'h7E, 8'h11, 8'h00}, 1'b1);
    mode <= 2'h2;
    send(0, '{8'h17, 8'h7E, 8'h7D, 8'h11, 8'h13});
    want(1, '{8'h17, 8'h7E, 8'h7D, 8'h11, 8'h13}, 1'b1);
    send(1, '{8'h97, 8'h13, 8'h7D});
    want(0, '{8'h97, 8'h13, 8'h7D}, 1'b1);
    mode <= 2'h1;
    foreach (hid[i]) begin
      send(0, '{hid[i], 8'h01});
      if (hid[i] != 8'h20)
        want(1, '{hid[i], 8'h01}, 1'b1);
    end
    foreach (did[i]) begin
      send(1, '{did[i], 8'h01});
      if (did[i] != 8'h42)
        want(0, '{did[i], 8'h01}, 1'b1);
    end
    send(1, '{8'h88, 8'h00});
    fmt <= 1'b1;
    send(1, '{8'h90, 8'h01});
    want(0, '{8'h91, 8'h01}, 1'b1);
    send(2, '{8'h55, 8'h13, 8'h7E, 8'h00, 8'h01, 8'h08, 8'hF7,
              8'h7E, 8'h00, 8'h01, 8'h08, 8'h00});
    want(2, '{8'h08}, 1'b1);
    want(2, '{8'h08}, 1'b0);
    want(3, '{8'h7E, 8'h00, 8'h02, 8'h8A, 8'h01, 8'h74}, 1'b0, 1'b0);
    // escaped mode: a delimiter inside a frame cuts it and reports a bad frame
    mode <= 2'h2;
    send(2, '{8'h7E, 8'h00, 8'h02, 8'h08, 8'h7E, 8'h00, 8'h01, 8'h08, 8'hF7});
    want(2, '{8'h08}, 1'b0);
    want(2, '{8'h08}, 1'b1);
    want(3, '{8'h7E, 8'h00, 8'h02, 8'h8A, 8'h02, 8'h73}, 1'b0, 1'b0);
    conclude();
  end
endmodule
